// ==== logic/tas_map.vh ====
// Register map, field positions, codes and timing for the acquisition sequencer
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz clock
`ifndef TAS_MAP_VH
`define TAS_MAP_VH
// Byte addresses
`define TAS_A_CMD 8'h00
`define TAS_A_MODE 8'h04
`define TAS_A_CHCFG 8'h08
`define TAS_A_CNTPRE 8'h0c
`define TAS_A_CNTPOST 8'h10
`define TAS_A_CNTSTOP 8'h14
`define TAS_A_INTNORM 8'h18
`define TAS_A_INTACQ 8'h1c
`define TAS_A_TRIG 8'h20
`define TAS_A_TERM 8'h24
`define TAS_A_POLL 8'h28
`define TAS_A_BUF 8'h2c
`define TAS_A_BLK 8'h30
`define TAS_A_ISTAT 8'h34
`define TAS_A_IMASK 8'h38
// Command register bits
`define TAS_CMD_EXEC 0
`define TAS_CMD_TRIGON 1
`define TAS_CMD_RDBLK 2
`define TAS_CMD_STOP 3
`define TAS_CMD_PORST 4
// Trigger sources
`define TAS_SRC_NONE 8'h00
`define TAS_START_CMD 8'h01
`define TAS_START_EXT 8'h02
`define TAS_STOP_CMD 8'h01
`define TAS_STOP_COUNT 8'h08
`define TAS_MODE_LINE 4'h0
// Poll byte bits
`define TAS_POLL_TRIG 1
`define TAS_POLL_READY 2
// Interrupt bits
`define TAS_IRQ_TRIG 0
`define TAS_IRQ_BLOCK 1
`define TAS_IRQ_READY 2
`define TAS_IRQ_OVF 3
// Reset values
`define TAS_STERM_RST 8'h0a
`define TAS_BTERM_RST 8'h0a
// Trigger register flag positions
`define TAS_TRIG_REARM 16
`define TAS_TRIG_SYNC 17
`define TAS_RESP_OK 2'b00
`define TAS_RESP_ERR 2'b10
// Timing
`define TAS_CLK_NS 100
`define TAS_TENTH_NS 100000000
`define TAS_READY_NS 2000000
`endif

// ==== logic/tas_pacer.v ====
// Scan pacer: one tick per programmed interval in tenths of a second
// Assumes the caller holds run high while a sequence is active
`timescale 1ns/100ps
module tas_pacer #(
	parameter TENTH_CYC = 1000000,
	parameter IW = 24
)(
	input wire clock, // System clock
	input wire rst, // Synchronous reset
	input wire run, // Pacing enabled
	input wire restart, // Restart the interval now
	input wire [IW-1:0] interval, // Interval in tenths, zero is fast
	output reg tick_q // One-cycle scan tick
);
	reg [31:0] cyc_q;
	reg [IW-1:0] ten_q;
	// Interval counting; zero interval scans every cycle
	always @(posedge clock)
	begin
		if (rst | ~run | restart)
		begin
			cyc_q <= 32'h0;
			ten_q <= {IW{1'b0}};
			tick_q <= run & restart;
		end
		else if (interval == {IW{1'b0}})
		begin
			tick_q <= 1'b1;
		end
		else if (cyc_q == TENTH_CYC - 1)
		begin
			cyc_q <= 32'h0;
			if (ten_q == interval - 1'b1)
			begin
				ten_q <= {IW{1'b0}};
				tick_q <= 1'b1;
			end
			else
			begin
				ten_q <= ten_q + 1'b1;
				tick_q <= 1'b0;
			end
		end
		else
		begin
			cyc_q <= cyc_q + 32'h1;
			tick_q <= 1'b0;
		end
	end
endmodule // tas_pacer

// ==== logic/tas_seq.v ====
// Triggered scan acquisition sequencer with AXI4-Lite registers
// Assumes one 10 MHz clock, a synchronous reset and an async trigger pin
// Operation
// - Ready bit set after reset, host polls
// - Mode chosen before scanning; zero is line-cycle
// - Channel command types a contiguous channel range
// - Three scan counts: pre, post, stop
// - Post count used only with count stop
// - Acquisition interval post; normal interval otherwise
// - Intervals given as time, tenths allowed
// - Zero post interval means fast scanning
// - Start on trigger-on command; stop on count
// - Auto re-arm after each completed acquisition
// - Sync flag restarts scan timing at trigger
// - Execute arms and starts pre-trigger scans
// - Separate scan and block terminators
// - Buffer status readable during and after
// - Block read returns oldest complete block
// - Clearing both sources disarms the sequencer
`timescale 1ns/100ps
`include "tas_map.vh"
module tas_seq #(
	parameter NCH = 48,
	parameter CW = 16,
	parameter IW = 24,
	parameter BDEPTH = 4,
	parameter BPW = 2,
	parameter TENTH_CYC = `TAS_TENTH_NS / `TAS_CLK_NS,
	parameter READY_CYC = `TAS_READY_NS / `TAS_CLK_NS
)(
	input wire clock, // System clock
	input wire rst, // Synchronous reset, high
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output wire [1:0] s_axi_bresp, // Write response
	output wire s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output wire [31:0] s_axi_rdata, // Read data
	output wire [1:0] s_axi_rresp, // Read response
	output wire s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire ext_trig, // External trigger pin
	output wire scan_pulse, // One scan taken
	output wire [7:0] scan_term, // Terminator after each scan
	output wire block_pulse, // Trigger block complete
	output wire [7:0] block_term, // Terminator after each block
	output wire [NCH*4-1:0] ch_types, // Sensor type per channel
	output wire irq // Interrupt, level high
);
	localparam ST_IDLE = 2'b00;
	localparam ST_PRE = 2'b01;
	localparam ST_POST = 2'b10;
	localparam ST_STOP = 2'b11;

	// Byte-lane merge of a write into a stored word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// Mapped address check, shared by read and write
	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'b00) && (a <= `TAS_A_IMASK);
		end
	endfunction

	reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	reg aw_hold_q, w_hold_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [1:0] bresp_q, rresp_q;
	reg [31:0] rdata_q;
	reg [1:0] state_q;
	reg [3:0] mode_q;
	reg mode_ok_q;
	reg [CW-1:0] cnt_pre_q, cnt_post_q, cnt_stop_q;
	reg [CW-1:0] pre_n_q, post_n_q, stop_n_q;
	reg [IW-1:0] int_norm_q, int_acq_q;
	reg [7:0] start_src_q, stop_src_q;
	reg rearm_q, sync_q;
	reg [7:0] sterm_q, bterm_q;
	reg [3:0] ch_type_q [0:NCH-1];
	reg [31:0] ready_cnt_q;
	reg ready_q, trig_seen_q, soft_q;
	reg [3:0] istat_q, imask_q;
	reg irq_q, scan_q, block_q;
	reg [CW-1:0] fifo_q [0:BDEPTH-1];
	reg [BPW-1:0] wp_q, rp_q;
	reg [BPW:0] blk_n_q;
	reg [CW+7:0] scans_q;
	reg [CW-1:0] blk_rd_q;
	reg ext1_q, ext2_q, ext3_q, ext_lvl_q, ext_old_q;
	reg [31:0] rd_word;
	wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
	wire srst = rst | soft_q;
	wire [31:0] wd = merge(32'h0, w_data_q, w_strb_q);
	wire cmd_wr = wr_go && aw_addr_q == `TAS_A_CMD;
	wire trig_wr = wr_go && aw_addr_q == `TAS_A_TRIG;
	wire tick;
	wire ext_rise = ext_lvl_q & ~ext_old_q;
	wire start_ev = (start_src_q == `TAS_START_CMD && cmd_wr && wd[`TAS_CMD_TRIGON])
		|| (start_src_q == `TAS_START_EXT && ext_rise);
	wire stop_cmd = stop_src_q == `TAS_STOP_CMD && cmd_wr && wd[`TAS_CMD_STOP];
	wire done = state_q == ST_STOP && stop_n_q >= cnt_stop_q;
	wire pop = cmd_wr && wd[`TAS_CMD_RDBLK] && blk_n_q != 0;
	wire push = done && blk_n_q != BDEPTH;
	wire [CW-1:0] tally = pre_n_q + post_n_q + stop_n_q;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign scan_pulse = scan_q;
	assign block_pulse = block_q;
	assign scan_term = sterm_q;
	assign block_term = bterm_q;
	assign irq = irq_q;

	// Scan pacing; acquisition interval only while post-trigger
	tas_pacer #(.TENTH_CYC(TENTH_CYC), .IW(IW)) u_pacer (
		.clock(clock),
		.rst(srst),
		.run(state_q != ST_IDLE),
		.restart(state_q == ST_PRE && start_ev && sync_q),
		.interval(state_q == ST_POST ? int_acq_q : int_norm_q),
		.tick_q(tick)
	);

	// Write channel capture, either order, response after both
	always @(posedge clock)
	begin
		if (rst)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `TAS_RESP_OK;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid & awready_q)
			begin
				aw_addr_q <= s_axi_awaddr;
				aw_hold_q <= 1'b1;
				awready_q <= 1'b0;
			end
			else if (wr_go)
			begin
				aw_hold_q <= 1'b0;
			end
			else if (~aw_hold_q)
			begin
				awready_q <= 1'b1;
			end
			if (s_axi_wvalid & wready_q)
			begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_hold_q <= 1'b1;
				wready_q <= 1'b0;
			end
			else if (wr_go)
			begin
				w_hold_q <= 1'b0;
			end
			else if (~w_hold_q)
			begin
				wready_q <= 1'b1;
			end
			if (wr_go)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= mapped(aw_addr_q) ? `TAS_RESP_OK : `TAS_RESP_ERR;
			end
			else if (s_axi_bready)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read word selection
	always @*
	begin
		rd_word = 32'h0;
		if (s_axi_araddr == `TAS_A_MODE)
			rd_word = {28'h0, mode_q};
		else if (s_axi_araddr == `TAS_A_CNTPRE)
			rd_word = {{(32-CW){1'b0}}, cnt_pre_q};
		else if (s_axi_araddr == `TAS_A_CNTPOST)
			rd_word = {{(32-CW){1'b0}}, cnt_post_q};
		else if (s_axi_araddr == `TAS_A_CNTSTOP)
			rd_word = {{(32-CW){1'b0}}, cnt_stop_q};
		else if (s_axi_araddr == `TAS_A_INTNORM)
			rd_word = {{(32-IW){1'b0}}, int_norm_q};
		else if (s_axi_araddr == `TAS_A_INTACQ)
			rd_word = {{(32-IW){1'b0}}, int_acq_q};
		else if (s_axi_araddr == `TAS_A_TRIG)
			rd_word = {14'h0, sync_q, rearm_q, stop_src_q, start_src_q};
		else if (s_axi_araddr == `TAS_A_TERM)
			rd_word = {16'h0, bterm_q, sterm_q};
		else if (s_axi_araddr == `TAS_A_POLL)
			rd_word = {24'h0, 2'b00, state_q, 1'b0, ready_q, trig_seen_q, 1'b0};
		else if (s_axi_araddr == `TAS_A_BUF)
			rd_word = {{(8-BPW-1){1'b0}}, blk_n_q, scans_q};
		else if (s_axi_araddr == `TAS_A_BLK)
			rd_word = {{(32-CW){1'b0}}, blk_rd_q};
		else if (s_axi_araddr == `TAS_A_ISTAT)
			rd_word = {28'h0, istat_q};
		else if (s_axi_araddr == `TAS_A_IMASK)
			rd_word = {28'h0, imask_q};
	end

	// Read channel, answer one cycle after the address
	always @(posedge clock)
	begin
		if (rst)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `TAS_RESP_OK;
		end
		else if (s_axi_arvalid & arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= mapped(s_axi_araddr) ? `TAS_RESP_OK : `TAS_RESP_ERR;
		end
		else if (rvalid_q & s_axi_rready)
		begin
			rvalid_q <= 1'b0;
		end
		else if (~rvalid_q)
		begin
			arready_q <= 1'b1;
		end
	end

	// Trigger pin: three stages, level moves when stages two and three agree
	always @(posedge clock)
	begin
		if (rst)
		begin
			ext1_q <= 1'b0;
			ext2_q <= 1'b0;
			ext3_q <= 1'b0;
			ext_lvl_q <= 1'b0;
			ext_old_q <= 1'b0;
		end
		else
		begin
			ext1_q <= ext_trig;
			ext2_q <= ext1_q;
			ext3_q <= ext2_q;
			if (ext2_q == ext3_q)
				ext_lvl_q <= ext3_q;
			ext_old_q <= ext_lvl_q;
		end
	end

	// Channel range typing, one slot per channel
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi = gi + 1)
		begin : g_ch
			always @(posedge clock)
			begin
				if (srst)
					ch_type_q[gi] <= 4'h0;
				else if (wr_go && aw_addr_q == `TAS_A_CHCFG
					&& gi + 1 >= wd[7:0] && gi + 1 <= wd[15:8])
					ch_type_q[gi] <= wd[19:16];
			end
			assign ch_types[gi*4 +: 4] = ch_type_q[gi];
		end
	endgenerate

	// Configuration registers and power-on reset command
	always @(posedge clock)
	begin
		if (srst)
		begin
			soft_q <= 1'b0;
			mode_q <= `TAS_MODE_LINE;
			mode_ok_q <= 1'b0;
			cnt_pre_q <= {CW{1'b0}};
			cnt_post_q <= {CW{1'b0}};
			cnt_stop_q <= {CW{1'b0}};
			int_norm_q <= {IW{1'b0}};
			int_acq_q <= {IW{1'b0}};
			start_src_q <= `TAS_SRC_NONE;
			stop_src_q <= `TAS_SRC_NONE;
			rearm_q <= 1'b0;
			sync_q <= 1'b0;
			sterm_q <= `TAS_STERM_RST;
			bterm_q <= `TAS_BTERM_RST;
			imask_q <= 4'h0;
		end
		else if (wr_go)
		begin
			soft_q <= cmd_wr && wd[`TAS_CMD_PORST];
			if (aw_addr_q == `TAS_A_MODE)
			begin
				mode_q <= wd[3:0];
				mode_ok_q <= 1'b1;
			end
			else if (aw_addr_q == `TAS_A_CNTPRE)
				cnt_pre_q <= wd[CW-1:0];
			else if (aw_addr_q == `TAS_A_CNTPOST)
				cnt_post_q <= wd[CW-1:0];
			else if (aw_addr_q == `TAS_A_CNTSTOP)
				cnt_stop_q <= wd[CW-1:0];
			else if (aw_addr_q == `TAS_A_INTNORM)
				int_norm_q <= wd[IW-1:0];
			else if (aw_addr_q == `TAS_A_INTACQ)
				int_acq_q <= wd[IW-1:0];
			else if (trig_wr)
			begin
				start_src_q <= wd[7:0];
				stop_src_q <= wd[15:8];
				rearm_q <= wd[`TAS_TRIG_REARM];
				sync_q <= wd[`TAS_TRIG_SYNC];
			end
			else if (aw_addr_q == `TAS_A_TERM)
			begin
				sterm_q <= wd[7:0];
				bterm_q <= wd[15:8];
			end
			else if (aw_addr_q == `TAS_A_IMASK)
				imask_q <= wd[3:0];
		end
		else
			soft_q <= 1'b0;
	end

	// Sequencer: idle, pre, post, stop, then complete
	always @(posedge clock)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			pre_n_q <= {CW{1'b0}};
			post_n_q <= {CW{1'b0}};
			stop_n_q <= {CW{1'b0}};
			trig_seen_q <= 1'b0;
			scan_q <= 1'b0;
			block_q <= 1'b0;
		end
		else
		begin
			scan_q <= tick && state_q != ST_IDLE;
			block_q <= done;
			if (trig_wr && wd[7:0] == `TAS_SRC_NONE && wd[15:8] == `TAS_SRC_NONE)
				state_q <= ST_IDLE;
			else
			case (state_q)
			ST_IDLE:
				if (cmd_wr && wd[`TAS_CMD_EXEC] && ready_q && mode_ok_q
					&& start_src_q != `TAS_SRC_NONE)
				begin
					state_q <= ST_PRE;
					pre_n_q <= {CW{1'b0}};
					trig_seen_q <= 1'b0;
				end
			ST_PRE:
			begin
				if (tick && pre_n_q < cnt_pre_q)
					pre_n_q <= pre_n_q + 1'b1;
				if (start_ev)
				begin
					state_q <= ST_POST;
					post_n_q <= {CW{1'b0}};
					trig_seen_q <= 1'b1;
				end
			end
			ST_POST:
				if ((stop_src_q == `TAS_STOP_COUNT && post_n_q >= cnt_post_q)
					|| stop_cmd)
				begin
					state_q <= ST_STOP;
					stop_n_q <= {CW{1'b0}};
				end
				else if (tick)
					post_n_q <= post_n_q + 1'b1;
			ST_STOP:
				if (done)
				begin
					state_q <= rearm_q ? ST_PRE : ST_IDLE;
					pre_n_q <= {CW{1'b0}};
					trig_seen_q <= 1'b0;
				end
				else if (tick)
					stop_n_q <= stop_n_q + 1'b1;
			default:
				state_q <= ST_IDLE;
			endcase
		end
	end

	// Block store: scan tallies of complete blocks, oldest read first
	always @(posedge clock)
	begin
		if (srst)
		begin
			wp_q <= {BPW{1'b0}};
			rp_q <= {BPW{1'b0}};
			blk_n_q <= {(BPW+1){1'b0}};
			scans_q <= {(CW+8){1'b0}};
			blk_rd_q <= {CW{1'b0}};
		end
		else
		begin
			if (push)
			begin
				fifo_q[wp_q] <= tally;
				wp_q <= wp_q + 1'b1;
			end
			if (pop)
			begin
				blk_rd_q <= fifo_q[rp_q];
				rp_q <= rp_q + 1'b1;
			end
			blk_n_q <= blk_n_q + {{BPW{1'b0}}, push} - {{BPW{1'b0}}, pop};
			scans_q <= scans_q + (push ? {8'h0, tally} : {(CW+8){1'b0}})
				- (pop ? {8'h0, fifo_q[rp_q]} : {(CW+8){1'b0}});
		end
	end

	// Ready bit after the settle time following any reset
	always @(posedge clock)
	begin
		if (srst)
		begin
			ready_cnt_q <= 32'h0;
			ready_q <= 1'b0;
		end
		else if (ready_cnt_q == READY_CYC - 1)
			ready_q <= 1'b1;
		else
			ready_cnt_q <= ready_cnt_q + 32'h1;
	end

	// Sticky events, write one to clear, set wins
	always @(posedge clock)
	begin
		if (srst)
		begin
			istat_q <= 4'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			istat_q <= (istat_q & ~((wr_go && aw_addr_q == `TAS_A_ISTAT) ? wd[3:0] : 4'h0))
				| {done && ~push, ready_cnt_q == READY_CYC - 1 && ~ready_q,
				done, state_q == ST_PRE && start_ev};
			irq_q <= |(istat_q & imask_q);
		end
	end
endmodule // tas_seq

// ==== bench/tas_seq_asserts.sv ====
// Checker of bus handshake, reset values and block pulse of the sequencer
// Assumes binding onto tas_seq; one clock, synchronous active-high reset
`timescale 1ns/100ps
module tas_seq_asserts (
	input wire clock, // Clock
	input wire rst, // Reset
	input wire s_axi_awready, // Address ready
	input wire s_axi_wready, // Data ready
	input wire [1:0] s_axi_bresp, // Write response
	input wire s_axi_bvalid, // Response valid
	input wire s_axi_bready, // Response ready
	input wire s_axi_arready, // Read address ready
	input wire [31:0] s_axi_rdata, // Read data
	input wire [1:0] s_axi_rresp, // Read response
	input wire s_axi_rvalid, // Read valid
	input wire s_axi_rready, // Read ready
	input wire block_pulse, // Block done
	input wire [7:0] scan_term, // Scan terminator
	input wire [7:0] block_term, // Block terminator
	input wire irq // Interrupt
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Rest values on leaving reset, readies one edge later
	rst_values_a:
	assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !block_pulse
		&& scan_term == 8'h0a && block_term == 8'h0a) else $error("reset values wrong");
	ready_up_a:
	assert property ($fell(rst) |=> s_axi_awready && s_axi_wready && s_axi_arready)
		else $error("readies not raised after reset");
	// Responses stand until taken, then drop
	bresp_hold_a:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	b_drop_a:
	assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	b_after_take_a:
	assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
		else $error("response before both channels taken");
	resp_code_a:
	assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
		else $error("bad write response code");
	rdata_hold_a:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_busy_a:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
	err_zero_a:
	assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
	block_once_a:
	assert property (block_pulse |=> !block_pulse [*4]) else $error("block pulse too long");
endmodule // tas_seq_asserts
bind tas_seq tas_seq_asserts i_tas_seq_asserts (.clock, .rst, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .block_pulse, .scan_term, .block_term, .irq);

// ==== bench/tas_host.sv ====
// Host controller model: AXI4-Lite master for the sequencer registers
// Assumes its tasks are called just after a rising clock edge
`timescale 1ns/100ps
`include "tas_map.vh"
module tas_host (
	input wire clock, // Clock
	output logic [7:0] s_axi_awaddr = 8'h00, // Write address
	output logic s_axi_awvalid = 1'h0, // Address valid
	input wire s_axi_awready, // Address ready
	output logic [31:0] s_axi_wdata = 32'h0, // Write data
	output wire [3:0] s_axi_wstrb, // Strobes
	output logic s_axi_wvalid = 1'h0, // Data valid
	input wire s_axi_wready, // Data ready
	input wire [1:0] s_axi_bresp, // Response
	input wire s_axi_bvalid, // Response valid
	output logic s_axi_bready = 1'h0, // Response ready
	output logic [7:0] s_axi_araddr = 8'h00, // Read address
	output logic s_axi_arvalid = 1'h0, // Address valid
	input wire s_axi_arready, // Address ready
	input wire [31:0] s_axi_rdata, // Read data
	input wire [1:0] s_axi_rresp, // Read response
	input wire s_axi_rvalid, // Read valid
	output logic s_axi_rready = 1'h0 // Read ready
);
	int tmo = 0; // Waits that ran out
	// Whole words only
	assign s_axi_wstrb = 4'hf;
	// Write: bready offered with the request, each channel released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		r = 2'h3;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		repeat (100)
		begin
			@(posedge clock);
			if (s_axi_bvalid && s_axi_bready)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				@(posedge clock);
				return;
			end
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		tmo++;
	endtask
	// Read: rready offered with the address, held until rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		r = 2'h3;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		repeat (100)
		begin
			@(posedge clock);
			if (s_axi_rvalid && s_axi_rready)
			begin
				v = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				@(posedge clock);
				return;
			end
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		tmo++;
	endtask
	// Power-on reset, then poll until the ready bit shows
	task automatic boot();
		logic [31:0] v = 32'h0;
		logic [1:0] r;
		wr(`TAS_A_CMD, 32'h10, r);
		repeat (50)
			if (!v[`TAS_POLL_READY])
				rd(`TAS_A_POLL, v, r);
		if (!v[`TAS_POLL_READY])
			tmo++;
	endtask
endmodule // tas_host

// ==== bench/testbench.sv ====
// Self-checking bench for the triggered acquisition sequencer
// Assumes tas_seq, its map header, the host model and the checker
`timescale 1ns/100ps
`include "tas_map.vh"
module testbench;
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic ext_trig = 1'h0;
	wire [7:0] s_axi_awaddr, s_axi_araddr, scan_term, block_term;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, scan_pulse, block_pulse, irq;
	wire [191:0] ch_types;
	int num_errors = 0;
	int check_count = 0;
	int nblk = 0;
	int nscan = 0;
	int tally[$];
	int p, s, k, b, n0;
	logic [31:0] d, seed = 32'h1a98f5c6;
	logic [1:0] r;
	tas_seq #(.TENTH_CYC(5), .READY_CYC(8)) i_tas_seq (.clock, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trig, .scan_pulse,
		.scan_term, .block_pulse, .block_term, .ch_types, .irq);
	tas_host i_tas_host (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	// Clock, completed-block and scan counters
	initial
		forever #50 clock = ~clock;
	always @(posedge clock)
	begin
		if (block_pulse === 1'h1)
			nblk <= nblk + 1;
		if (scan_pulse === 1'h1)
			nscan <= nscan + 1;
	end
	// Fixed-seed xorshift
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_sim();
		num_errors += i_tas_host.tmo;
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bus access with response check; a hung host ends the run
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		i_tas_host.wr(a, v, r);
		if (i_tas_host.tmo != 0)
			end_sim();
		chk(r, e);
	endtask
	task rd(input logic [7:0] a, input logic [1:0] e);
		i_tas_host.rd(a, d, r);
		if (i_tas_host.tmo != 0)
			end_sim();
		chk(r, e);
	endtask
	task st(input int e);
		rd(`TAS_A_POLL, 2'h0);
		chk(d[5:4], e);
	endtask
	task boot();
		i_tas_host.boot();
		if (i_tas_host.tmo != 0)
			end_sim();
	endtask
	// Bounded wait for a block after n0 was captured
	task wblk(input int lim);
		for (k = 0; k < lim && nblk == n0; k++)
			@(posedge clock);
		if (nblk == n0)
		begin
			num_errors++;
			end_sim();
		end
	endtask
	initial
	begin
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		boot();
		chk({block_term, scan_term}, 16'h0a0a);
		rd(8'h3c, 2'h2);
		chk(d, 0);
		wr(8'h40, 0, 2'h2);
		wr(`TAS_A_MODE, `TAS_MODE_LINE, 2'h0);
		wr(`TAS_A_CHCFG, 32'h010c01, 2'h0);
		wr(`TAS_A_CHCFG, 32'h022419, 2'h0);
		for (k = 1; k <= 48; k++)
			chk(ch_types[4*k-4 +: 4], k <= 12 ? 1 : (k >= 25 && k <= 36 ? 2 : 0));
		p = rnd() % 4 + 1;
		s = rnd() % 3 + 1;
		d = rnd();
		wr(`TAS_A_TERM, d[15:0], 2'h0);
		repeat (2) @(posedge clock);
		chk({block_term, scan_term}, d[15:0]);
		wr(`TAS_A_CNTPRE, p, 2'h0);
		wr(`TAS_A_CNTPOST, 6, 2'h0);
		wr(`TAS_A_INTNORM, 1, 2'h0);
		wr(`TAS_A_INTACQ, 0, 2'h0);
		wr(`TAS_A_TRIG, 32'h10801, 2'h0);
		wr(`TAS_A_IMASK, 32'h2, 2'h0);
		wr(`TAS_A_CMD, 32'h1, 2'h0);
		st(1);
		for (b = 0; b < 2; b++)
		begin
			wr(`TAS_A_CNTSTOP, s + b, 2'h0);
			n0 = nscan;
			repeat (40) @(posedge clock);
			chk(nscan - n0, 8);
			n0 = nblk;
			wr(`TAS_A_CMD, 32'h2, 2'h0);
			repeat (2) @(posedge clock);
			chk(irq, 0);
			wblk(6 + 5 * (s + b) + 15);
			tally.push_back(p + 6 + s + b);
			repeat (3) @(posedge clock);
			chk(irq, 1);
			st(1);
			rd(`TAS_A_BUF, 2'h0);
			chk(d[26:24], tally.size());
			wr(`TAS_A_ISTAT, 32'h2, 2'h0);
			repeat (2) @(posedge clock);
			chk(irq, 0);
		end
		while (tally.size() > 0)
		begin
			wr(`TAS_A_CMD, 32'h4, 2'h0);
			rd(`TAS_A_BLK, 2'h0);
			chk(d, tally.pop_front());
			rd(`TAS_A_BUF, 2'h0);
			chk(d[26:24], tally.size());
		end
		wr(`TAS_A_TRIG, 0, 2'h0);
		st(0);
		n0 = nscan;
		repeat (20) @(posedge clock);
		chk(nscan - n0, 0);
		wr(`TAS_A_TRIG, 32'h20102, 2'h0);
		wr(`TAS_A_CMD, 32'h1, 2'h0);
		repeat (20) @(posedge clock);
		ext_trig <= 1'h1;
		repeat (40) @(posedge clock);
		st(2);
		n0 = nblk;
		wr(`TAS_A_CMD, 32'h8, 2'h0);
		wblk(40);
		st(0);
		ext_trig <= 1'h0;
		boot();
		rd(`TAS_A_BUF, 2'h0);
		chk(d[26:24], 0);
		wr(`TAS_A_TRIG, 32'h801, 2'h0);
		wr(`TAS_A_CMD, 32'h1, 2'h0);
		st(0);
		wr(`TAS_A_MODE, `TAS_MODE_LINE, 2'h0);
		wr(`TAS_A_CMD, 32'h1, 2'h0);
		st(1);
		end_sim();
	end
endmodule // testbench
